// ### hw/clock_split.sv
// Bus clock phase, self-reset tick and wakeup timer clock select
`timescale 1ns/1ps
module clock_split #(
  parameter int SELF_RESET_DIV = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sys_resetn,
  input wire logic wake_sel_lpo,
  input wire logic lpo_clk_in,
  output logic core_tick,
  output logic bus_tick,
  output logic self_reset_tick,
  output logic wake_tick
);
  // ==========================================================
  // Core and bus clock
  logic bus_phase_q;
  logic lpo_q;
  logic [15:0] div_q;

  assign core_tick = 1'b1;

  // Divider restarts with every reset so the phase is known
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_phase_q <= 1'b0;
    end else if (!sys_resetn) begin
      bus_phase_q <= 1'b0;
    end else begin
      bus_phase_q <= ~bus_phase_q;
    end
  end
  assign bus_tick = bus_phase_q;

  // ==========================================================
  // Self-reset clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= 16'h0000;
    end else if (div_q == 16'(SELF_RESET_DIV - 1)) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end
  assign self_reset_tick = (div_q == 16'(SELF_RESET_DIV - 1));

  // ==========================================================
  // Wakeup timer source, low-rate input taken as synchronous
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lpo_q <= 1'b0;
    end else begin
      lpo_q <= lpo_clk_in;
    end
  end
  assign wake_tick = wake_sel_lpo ? (lpo_clk_in & ~lpo_q) : 1'b1;

  // ==========================================================
  // Checks
  a_bus_half_rate: assert property (@(posedge clk) disable iff (!resetn)
    sys_resetn && $past(sys_resetn) |-> bus_tick != $past(bus_tick))
    else $error("bus clock not at half rate");
  a_bus_phase_reset: assert property (@(posedge clk) disable iff (!resetn)
    !sys_resetn |=> !bus_tick)
    else $error("bus clock phase not reset");
endmodule : clock_split

// ### hw/debug_bit_timer.sv
// Single-wire debug link bit timing with speedup pulse
`timescale 1ns/1ps
module debug_bit_timer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic dbg_tick,
  input wire logic link_en,
  input wire logic tx_start,
  input wire logic tx_bit,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n,
  output logic busy,
  output logic rx_valid,
  output logic rx_bit
);
  // ==========================================================
  // Bit cell counter
  logic [4:0] cnt_q;
  logic tx_q;
  logic val_q;
  logic [4:0] low_len;
  logic pin_q;
  logic run_q;

  assign low_len = val_q ? rst_mode_pkg::BIT_LOW_ONE : rst_mode_pkg::BIT_LOW_ZERO;
  assign busy = run_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_q <= 1'b0;
      tx_q <= 1'b0;
      val_q <= 1'b0;
      cnt_q <= 5'h00;
    end else if (!link_en) begin
      run_q <= 1'b0;
      tx_q <= 1'b0;
      cnt_q <= 5'h00;
    end else if (!run_q) begin
      cnt_q <= 5'h00;
      if (tx_start) begin
        run_q <= 1'b1;
        tx_q <= 1'b1;
        val_q <= tx_bit;
      end else if (pin_q && !pin_in) begin
        run_q <= 1'b1;
        tx_q <= 1'b0;
      end
    end else if (dbg_tick) begin
      if (cnt_q == rst_mode_pkg::BIT_TICKS - 5'h01) begin
        run_q <= 1'b0;
        tx_q <= 1'b0;
      end
      cnt_q <= cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= pin_in;
    end
  end

  // ==========================================================
  // Receive sample, host starts the cell with a falling edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_valid <= 1'b0;
      rx_bit <= 1'b0;
    end else begin
      rx_valid <= run_q && !tx_q && dbg_tick && cnt_q == rst_mode_pkg::BIT_SAMPLE;
      if (run_q && !tx_q && dbg_tick && cnt_q == rst_mode_pkg::BIT_SAMPLE) begin
        rx_bit <= pin_in;
      end
    end
  end

  // ==========================================================
  // Drive low, one speedup cycle high, then release to the pullup
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_out <= 1'b1;
      pin_oe_n <= 1'b1;
    end else if (run_q && tx_q && cnt_q < low_len) begin
      pin_out <= 1'b0;
      pin_oe_n <= 1'b0;
    end else if (run_q && tx_q && cnt_q == low_len) begin
      pin_out <= 1'b1;
      pin_oe_n <= 1'b0;
    end else begin
      pin_out <= 1'b1;
      pin_oe_n <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  a_bit_cell_end: assert property (@(posedge clk) disable iff (!resetn)
    run_q && link_en && dbg_tick && cnt_q == 5'h0F |=> !run_q)
    else $error("bit cell not sixteen ticks");
  a_speedup_high: assert property (@(posedge clk) disable iff (!resetn)
    run_q && tx_q && cnt_q == low_len |=> pin_out && !pin_oe_n)
    else $error("speedup pulse missing");
  c_tx_bit: cover property (@(posedge clk) disable iff (!resetn) tx_start && link_en);
endmodule : debug_bit_timer

// ### hw/reset_pin_mode_select_clocking.sv
// Reset pin sequencer, mode select latch, pin sharing and clock split
// ==========================================================
// Summary of operation
// - Core runs at oscillator rate, undivided
// - Bus clock is half oscillator rate
// - Wakeup timer clock selectable: oscillator or low-rate
// - Reset pin is reset input only when enabled
// - Every reset sets the reset pin enable
// - Drive reset pin low 34 self-reset periods
// - Wait 38 periods, then sample pin once
// - Low sample on internal reset means external
// - Record decoded cause in reset cause register
// - Debug pin selects mode in reset, debug after
// - Pullup on while debug or mode function
// - Debug pin becomes port when enable cleared
// - High mode pin at release: normal mode
// - Low mode pin at release: active background
// - Debug bit time is sixteen controller cycles
// - Debug controller runs at bus clock rate
// - Releasing party drives short high speedup pulse
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
module reset_pin_mode_select_clocking #(
  parameter int NUM_INT_SRC = 4,
  parameter int SELF_RESET_DIV = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  input wire logic [NUM_INT_SRC-1:0] int_reset_req,
  input wire logic lpo_clk_in,
  input wire logic reset_port_pin_in,
  output logic reset_port_pin_out,
  output logic reset_port_pin_oe_n,
  output logic reset_port_pin_pullup,
  input wire logic port_d1_data,
  input wire logic debug_port_pin_in,
  output logic debug_port_pin_out,
  output logic debug_port_pin_oe_n,
  output logic debug_port_pin_pullup,
  input wire logic port_d0_data,
  input wire logic dbg_tx_start,
  input wire logic dbg_tx_bit,
  output logic dbg_busy,
  output logic dbg_rx_valid,
  output logic dbg_rx_bit,
  output logic sys_resetn,
  output logic active_background,
  output logic core_tick,
  output logic bus_tick,
  output logic wake_tick
);
  // ==========================================================
  // Sequencer state
  typedef enum logic [3:0] {
    ST_DRIVE = 4'h1,
    ST_WAIT = 4'h2,
    ST_SAMPLE = 4'h4,
    ST_RUN = 4'h8
  } seq_state_t;

  seq_state_t state_q;
  logic [5:0] tick_cnt_q;
  logic self_reset_tick;
  logic pend_por_q;
  logic pend_ext_q;
  logic [NUM_INT_SRC-1:0] pend_int_q;
  logic [7:0] opt_q;
  logic [7:0] cause_q;
  logic [7:0] cause_d;
  logic ext_req;
  logic int_req;
  logic start_seq;
  logic reset_pin_enable;
  logic debug_pin_enable;
  logic dbg_out;
  logic dbg_oe_n;
  logic dbg_link_en;

  assign reset_pin_enable = opt_q[rst_mode_pkg::OPT_RESET_PIN_EN_BIT];
  assign debug_pin_enable = opt_q[rst_mode_pkg::OPT_DEBUG_PIN_EN_BIT];
  assign ext_req = reset_pin_enable && !reset_port_pin_in;
  assign int_req = |int_reset_req;
  assign start_seq = (state_q == ST_RUN) && (ext_req || int_req);
  assign sys_resetn = (state_q == ST_RUN);

  // ==========================================================
  // Clock split
  clock_split #(
    .SELF_RESET_DIV(SELF_RESET_DIV)
  ) u_clk (
    .clk(clk),
    .resetn(resetn),
    .sys_resetn(sys_resetn),
    .wake_sel_lpo(opt_q[rst_mode_pkg::OPT_WAKE_SEL_BIT]),
    .lpo_clk_in(lpo_clk_in),
    .core_tick(core_tick),
    .bus_tick(bus_tick),
    .self_reset_tick(self_reset_tick),
    .wake_tick(wake_tick)
  );

  // ==========================================================
  // Reset sequence
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_DRIVE;
      tick_cnt_q <= 6'h00;
    end else begin
      unique case (state_q)
        ST_DRIVE: begin
          if (self_reset_tick) begin
            if (tick_cnt_q == rst_mode_pkg::PIN_DRIVE_TICKS - 6'h01) begin
              state_q <= ST_WAIT;
              tick_cnt_q <= 6'h00;
            end else begin
              tick_cnt_q <= tick_cnt_q + 6'h01;
            end
          end
        end
        ST_WAIT: begin
          if (self_reset_tick) begin
            if (tick_cnt_q == rst_mode_pkg::PIN_WAIT_TICKS - 6'h01) begin
              state_q <= ST_SAMPLE;
              tick_cnt_q <= 6'h00;
            end else begin
              tick_cnt_q <= tick_cnt_q + 6'h01;
            end
          end
        end
        ST_SAMPLE: begin
          state_q <= ST_RUN;
        end
        ST_RUN: begin
          if (start_seq) begin
            state_q <= ST_DRIVE;
            tick_cnt_q <= 6'h00;
          end
        end
      endcase
    end
  end

  // Sources are held until the sample so the cause survives the pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_por_q <= 1'b1;
      pend_ext_q <= 1'b0;
      pend_int_q <= '0;
    end else if (start_seq) begin
      pend_por_q <= 1'b0;
      pend_ext_q <= ext_req && !int_req;
      pend_int_q <= int_reset_req;
    end
  end

  // ==========================================================
  // Cause decode
  always_comb begin
    cause_d = 8'h00;
    if (pend_por_q) begin
      cause_d[rst_mode_pkg::CAUSE_POR_BIT] = 1'b1;
    end else if (pend_ext_q || !reset_port_pin_in) begin
      cause_d[rst_mode_pkg::CAUSE_EXT_BIT] = 1'b1;
    end else begin
      cause_d[rst_mode_pkg::CAUSE_INT_LSB +: NUM_INT_SRC] = pend_int_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cause_q <= rst_mode_pkg::CAUSE_RESET_VALUE;
    end else if (state_q == ST_SAMPLE) begin
      cause_q <= cause_d;
    end
  end

  // ==========================================================
  // System options, writes ignored while the device is in reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      opt_q <= rst_mode_pkg::OPT_RESET_VALUE;
    end else if (state_q != ST_RUN) begin
      opt_q <= rst_mode_pkg::OPT_RESET_VALUE;
    end else if (reg_we && reg_addr == rst_mode_pkg::OPT_OFFSET) begin
      opt_q <= {5'h00, reg_wdata[2:0]};
    end
  end

  // ==========================================================
  // Register read port
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_re && reg_addr == rst_mode_pkg::OPT_OFFSET) begin
      reg_rdata <= opt_q;
    end else if (reg_re && reg_addr == rst_mode_pkg::CAUSE_OFFSET) begin
      reg_rdata <= cause_q;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // Mode select latch at reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_background <= 1'b0;
    end else if (state_q == ST_SAMPLE) begin
      active_background <= !debug_port_pin_in;
    end
  end

  // ==========================================================
  // Debug link, clocked at the bus rate
  assign dbg_link_en = sys_resetn && debug_pin_enable;

  debug_bit_timer u_dbg (
    .clk(clk),
    .resetn(resetn),
    .dbg_tick(bus_tick),
    .link_en(dbg_link_en),
    .tx_start(dbg_tx_start),
    .tx_bit(dbg_tx_bit),
    .pin_in(debug_port_pin_in),
    .pin_out(dbg_out),
    .pin_oe_n(dbg_oe_n),
    .busy(dbg_busy),
    .rx_valid(dbg_rx_valid),
    .rx_bit(dbg_rx_bit)
  );

  // ==========================================================
  // Pin sharing
  always_comb begin
    if (state_q == ST_DRIVE) begin
      reset_port_pin_out = 1'b0;
      reset_port_pin_oe_n = 1'b0;
      reset_port_pin_pullup = 1'b1;
    end else if (reset_pin_enable) begin
      reset_port_pin_out = 1'b1;
      reset_port_pin_oe_n = 1'b1;
      reset_port_pin_pullup = 1'b1;
    end else begin
      reset_port_pin_out = port_d1_data;
      reset_port_pin_oe_n = 1'b0;
      reset_port_pin_pullup = 1'b0;
    end
  end

  // A port write cannot disturb mode select: the port only takes over in run
  always_comb begin
    if (!sys_resetn) begin
      debug_port_pin_out = 1'b1;
      debug_port_pin_oe_n = 1'b1;
      debug_port_pin_pullup = 1'b1;
    end else if (debug_pin_enable) begin
      debug_port_pin_out = dbg_out;
      debug_port_pin_oe_n = dbg_oe_n;
      debug_port_pin_pullup = 1'b1;
    end else begin
      debug_port_pin_out = port_d0_data;
      debug_port_pin_oe_n = 1'b0;
      debug_port_pin_pullup = 1'b0;
    end
  end

  // ==========================================================
  // Checks
  a_drive_pin_low: assert property (@(posedge clk) disable iff (!resetn)
    state_q == ST_DRIVE |-> !reset_port_pin_out && !reset_port_pin_oe_n)
    else $error("reset pin not driven low");
  a_drive_count: assert property (@(posedge clk) disable iff (!resetn)
    state_q == ST_DRIVE ##1 state_q == ST_WAIT |-> $past(tick_cnt_q) == 6'h21)
    else $error("drive length wrong");
  a_wait_count: assert property (@(posedge clk) disable iff (!resetn)
    state_q == ST_WAIT ##1 state_q == ST_SAMPLE |-> $past(tick_cnt_q) == 6'h25)
    else $error("wait length wrong");
  a_ext_cause: assert property (@(posedge clk) disable iff (!resetn)
    state_q == ST_SAMPLE && !pend_por_q && !reset_port_pin_in |=> cause_q == 8'h40)
    else $error("low sample not external");
  a_int_cause: assert property (@(posedge clk) disable iff (!resetn)
    state_q == ST_SAMPLE && !pend_por_q && !pend_ext_q && reset_port_pin_in
    |=> cause_q[NUM_INT_SRC-1:0] == $past(pend_int_q))
    else $error("internal cause not recorded");
  a_enable_on_reset: assert property (@(posedge clk) disable iff (!resetn)
    start_seq |=> ##1 reset_pin_enable && debug_pin_enable)
    else $error("pin enables not set by reset");
  a_mode_latch: assert property (@(posedge clk) disable iff (!resetn)
    state_q == ST_SAMPLE |=> active_background == !$past(debug_port_pin_in))
    else $error("mode not latched at release");
  a_port_handover: assert property (@(posedge clk) disable iff (!resetn)
    sys_resetn && !debug_pin_enable |-> !debug_port_pin_oe_n && !debug_port_pin_pullup)
    else $error("debug pin not handed to port");
  a_pullup_mode: assert property (@(posedge clk) disable iff (!resetn)
    !sys_resetn |-> debug_port_pin_pullup && debug_port_pin_oe_n)
    else $error("mode select pin not pulled up");
  c_ext_reset: cover property (@(posedge clk) disable iff (!resetn) start_seq && ext_req);
  c_int_reset: cover property (@(posedge clk) disable iff (!resetn) start_seq && int_req);
  c_background: cover property (@(posedge clk) disable iff (!resetn)
    state_q == ST_SAMPLE && !debug_port_pin_in);
  c_port_mode: cover property (@(posedge clk) disable iff (!resetn)
    sys_resetn && !reset_pin_enable);
endmodule : reset_pin_mode_select_clocking

// ### hw/rst_mode_pkg.sv
// Shared constants for the reset pin, mode select and clock split logic
package rst_mode_pkg;
  // ==========================================================
  // Register map
  localparam logic [3:0] OPT_OFFSET = 4'h0;
  localparam logic [3:0] CAUSE_OFFSET = 4'h4;
  // ==========================================================
  // System options fields
  localparam int OPT_RESET_PIN_EN_BIT = 0;
  localparam int OPT_DEBUG_PIN_EN_BIT = 1;
  localparam int OPT_WAKE_SEL_BIT = 2;
  localparam logic [7:0] OPT_RESET_VALUE = 8'h03;
  // ==========================================================
  // Reset cause fields
  localparam int CAUSE_POR_BIT = 7;
  localparam int CAUSE_EXT_BIT = 6;
  localparam int CAUSE_INT_LSB = 0;
  localparam logic [7:0] CAUSE_RESET_VALUE = 8'h80;
  // ==========================================================
  // Reset pin sequence counts, in self-reset clock periods
  localparam logic [5:0] PIN_DRIVE_TICKS = 6'h22;
  localparam logic [5:0] PIN_WAIT_TICKS = 6'h26;
  // ==========================================================
  // Debug link bit timing, in debug controller clock cycles
  localparam logic [4:0] BIT_TICKS = 5'h10;
  localparam logic [4:0] BIT_LOW_ZERO = 5'h0D;
  localparam logic [4:0] BIT_LOW_ONE = 5'h04;
  localparam logic [4:0] BIT_SAMPLE = 5'h0A;
endpackage : rst_mode_pkg

// ### sim/pin_partner.sv
// Model of the external reset source and the debug host at the two pins
`timescale 1ns/1ps
module pin_partner (
  input wire logic clk,
  input wire logic rst_hold,
  input wire logic ms_hold,
  input wire logic host_start,
  input wire logic host_bit,
  input wire logic rst_out,
  input wire logic rst_oe_n,
  input wire logic rst_pullup,
  input wire logic dbg_out,
  input wire logic dbg_oe_n,
  input wire logic dbg_pullup,
  output logic rst_level,
  output logic dbg_level
);
  // ==========================================================
  // Host bit cell: 16 debug clocks of two oscillator cycles
  logic [5:0] el_q = 6'h20;
  logic [5:0] low;
  logic host_drv;
  logic rst_last_q = 1'b1;
  logic dbg_last_q = 1'b1;
  assign low = host_bit ? 6'h08 : 6'h1A;
  assign host_drv = el_q < low + 6'h02;
  always @(posedge clk) begin
    if (host_start) begin
      el_q <= 6'h00;
    end else if (el_q != 6'h20) begin
      el_q <= el_q + 6'h01;
    end
  end
  // ==========================================================
  // Wire levels
  // A strong outside pull wins; an undriven wire without pullup wanders every cycle
  // Holding the mode pin low across reset release asks for background mode
  assign rst_level = rst_hold ? 1'b0 : !rst_oe_n ? rst_out : rst_pullup ? 1'b1 : !rst_last_q;
  assign dbg_level = ms_hold ? 1'b0 : host_drv ? (el_q >= low) : !dbg_oe_n ? dbg_out
                   : dbg_pullup ? 1'b1 : !dbg_last_q;
  always @(posedge clk) begin
    rst_last_q <= rst_level;
    dbg_last_q <= dbg_level;
  end
endmodule : pin_partner

// ### sim/reset_pin_mode_select_clocking_tb_top.sv
// Testbench for the reset pin sequencer, mode select and clock split
`timescale 1ns/1ps
module reset_pin_mode_select_clocking_tb_top;
  localparam int DIV = 2;
  localparam logic [3:0] OPT = rst_mode_pkg::OPT_OFFSET;
  localparam logic [3:0] CAUSE = rst_mode_pkg::CAUSE_OFFSET;
  logic clk = 0, resetn = 0, reg_we = 0, reg_re = 0, lpo = 0, d1 = 0, d0 = 0;
  logic tx_start = 0, tx_bit = 0, rst_hold = 0, ms_hold = 0, host_start = 0, host_bit = 0;
  logic [3:0] reg_addr = '0, int_req = '0, lpo_cnt = '0;
  logic [7:0] reg_wdata = '0, reg_rdata;
  logic rst_in, rst_out, rst_oe_n, rst_pu, dbg_in, dbg_out, dbg_oe_n, dbg_pu;
  logic busy, rx_valid, rx_bit, sys_resetn, act_bg, core_tick, bus_tick, wake_tick;
  int errors = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    lpo_cnt <= lpo_cnt + 4'h1;
    lpo <= lpo_cnt[3];
  end
  reset_pin_mode_select_clocking #(.NUM_INT_SRC(4), .SELF_RESET_DIV(DIV)) dut (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .int_reset_req(int_req),
    .lpo_clk_in(lpo), .reset_port_pin_in(rst_in), .reset_port_pin_out(rst_out),
    .reset_port_pin_oe_n(rst_oe_n), .reset_port_pin_pullup(rst_pu), .port_d1_data(d1),
    .debug_port_pin_in(dbg_in), .debug_port_pin_out(dbg_out),
    .debug_port_pin_oe_n(dbg_oe_n), .debug_port_pin_pullup(dbg_pu), .port_d0_data(d0),
    .dbg_tx_start(tx_start), .dbg_tx_bit(tx_bit), .dbg_busy(busy),
    .dbg_rx_valid(rx_valid), .dbg_rx_bit(rx_bit), .sys_resetn(sys_resetn),
    .active_background(act_bg), .core_tick(core_tick), .bus_tick(bus_tick),
    .wake_tick(wake_tick));
  pin_partner far (
    .clk(clk), .rst_hold(rst_hold), .ms_hold(ms_hold), .host_start(host_start),
    .host_bit(host_bit), .rst_out(rst_out), .rst_oe_n(rst_oe_n), .rst_pullup(rst_pu),
    .dbg_out(dbg_out), .dbg_oe_n(dbg_oe_n), .dbg_pullup(dbg_pu), .rst_level(rst_in),
    .dbg_level(dbg_in));
  // ==========================================================
  // Bus and checking tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string msg);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 chk(reg_rdata, exp, msg);
  endtask : rd
  task automatic wait_run();
    int n;
    n = 0;
    while (sys_resetn !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1 n++;
    end
    chk(n < 400, 1, "sequence hung");
  endtask : wait_run
  // Times the pin drive and the release gap of one internally caused reset
  task automatic int_reset(input logic [3:0] src, input logic hold);
    int lo, rel;
    lo = 0;
    rel = 0;
    @(posedge clk);
    int_req <= src;
    @(posedge clk);
    int_req <= '0;
    rst_hold <= hold;
    #1 while (rst_oe_n === 1'b0 && lo < 400) begin
      @(posedge clk);
      #1 lo++;
    end
    while (sys_resetn !== 1'b1 && rel < 400) begin
      @(posedge clk);
      #1 rel++;
    end
    chk(lo >= 33 * DIV && lo <= 35 * DIV, 1, "drive length");
    chk(rel >= 37 * DIV && rel <= 39 * DIV + 2, 1, "release gap");
  endtask : int_reset
  task automatic dbg_tx(input logic v);
    int nb, lo, sp;
    nb = 0;
    lo = 0;
    sp = 0;
    @(posedge clk);
    tx_start <= 1'b1;
    tx_bit <= v;
    @(posedge clk);
    tx_start <= 1'b0;
    repeat (40) begin
      #1 nb += busy;
      lo += !dbg_in;
      sp += (!dbg_oe_n && dbg_out);
      @(posedge clk);
    end
    chk(nb >= 31 && nb <= 33, 1, "bit cell length");
    chk(lo >= (v ? 7 : 25) && lo <= (v ? 9 : 27), 1, "low time");
    chk(sp > 0, 1, "no speedup pulse");
  endtask : dbg_tx
  task automatic dbg_rx(input logic v);
    int n;
    n = 0;
    @(posedge clk);
    host_start <= 1'b1;
    host_bit <= v;
    @(posedge clk);
    host_start <= 1'b0;
    #1 while (rx_valid !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1 n++;
    end
    chk({n < 60, rx_bit}, {1'b1, v}, "received bit");
    repeat (40) @(posedge clk);
  endtask : dbg_rx
  task automatic wake_count(output int n);
    n = 0;
    repeat (64) begin
      @(posedge clk);
      #1 n += wake_tick;
    end
  endtask : wake_count
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  // ==========================================================
  // Test sequence
  initial begin
    logic b;
    int n;
    repeat (16) @(posedge clk);
    #1 chk(bus_tick, 0, "bus phase in reset");
    chk({rst_oe_n, rst_out}, 0, "reset pin not low");
    chk({dbg_oe_n, dbg_pu}, 2'b11, "mode pin not released");
    @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1 wait_run();
    rd(OPT, rst_mode_pkg::OPT_RESET_VALUE, "options after reset");
    rd(CAUSE, 8'h80, "power-on cause");
    chk({act_bg, core_tick, dbg_pu}, 3'b011, "mode, core or pullup");
    b = bus_tick;
    @(posedge clk);
    #1 chk(bus_tick, !b, "bus phase stuck");
    for (int i = 0; i < 4; i++) begin
      int_reset(4'h1 << i, 1'b0);
      rd(CAUSE, 8'h01 << i, "internal cause");
    end
    @(posedge clk);
    rst_hold <= 1'b1;
    repeat (3) @(posedge clk);
    rst_hold <= 1'b0;
    #1 chk(sys_resetn, 0, "pin reset not taken");
    wait_run();
    rd(CAUSE, 8'h40, "external cause");
    // Pin still low at the sample point turns an internal reset into an external one
    int_reset(4'h2, 1'b1);
    // A pin still held restarts a pin reset at once, so read the cause before it is rewritten
    rd(CAUSE, 8'h40, "held pin cause");
    @(posedge clk);
    rst_hold <= 1'b0;
    repeat (2) @(posedge clk);
    #1 wait_run();
    rd(CAUSE, 8'h40, "pin restart cause");
    wr(OPT, 8'h02);
    @(posedge clk);
    d1 <= 1'b1;
    rst_hold <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk({sys_resetn, rst_oe_n, rst_out, rst_pu}, 4'b1010, "reset pin as port");
    @(posedge clk);
    rst_hold <= 1'b0;
    d1 <= 1'b0;
    @(posedge clk);
    #1 chk(rst_out, 0, "port data on reset pin");
    int_reset(4'h1, 1'b0);
    rd(OPT, 8'h03, "enables restored");
    for (int i = 0; i < 2; i++) begin
      dbg_tx(i[0]);
      dbg_rx(i[0]);
    end
    wr(CAUSE, 8'hFF);
    rd(CAUSE, 8'h01, "cause written");
    rd(4'h8, 8'h00, "unmapped read");
    wr(OPT, 8'h01);
    @(posedge clk);
    d0 <= 1'b1;
    @(posedge clk);
    #1 chk({dbg_oe_n, dbg_out, dbg_pu}, 3'b010, "debug pin as port");
    wr(OPT, 8'hFF);
    rd(OPT, 8'h07, "options width");
    wake_count(n);
    chk(n >= 3 && n <= 5, 1, "slow wake clock");
    wr(OPT, 8'h03);
    wake_count(n);
    chk(n == 64, 1, "oscillator wake clock");
    @(posedge clk);
    ms_hold <= 1'b1;
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk({bus_tick, dbg_pu}, 2'b01, "phase or pullup in reset");
    @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1 wait_run();
    @(posedge clk);
    ms_hold <= 1'b0;
    #1 chk(act_bg, 1, "background mode");
    int_reset(4'h4, 1'b0);
    chk(act_bg, 0, "normal mode");
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule : reset_pin_mode_select_clocking_tb_top
